/* File: core/tlstw_defs.svh */
`ifndef TLSTW_DEFS_SVH
`define TLSTW_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the AXI4-Lite port)
// ----------------------------------------------------------------------
`define TLSTW_OFS_CTRL 8'h00
`define TLSTW_OFS_BASE_LO 8'h04
`define TLSTW_OFS_BASE_HI 8'h08
`define TLSTW_OFS_SPLIT 8'h0C
`define TLSTW_OFS_INVAL 8'h10
`define TLSTW_OFS_STATUS 8'h14
`define TLSTW_OFS_EVENT 8'h18

// ----------------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------------
`define TLSTW_CTRL_EN 0
`define TLSTW_CTRL_REC 1
`define TLSTW_CTRL_ATTR_LSB 8
`define TLSTW_CTRL_RST 32'h0000_0000
`define TLSTW_SPLIT_RST 4'h6
`define TLSTW_INVAL_GLOBAL 16
`define TLSTW_INVAL_RANGE 17
`define TLSTW_RESP_OKAY 2'h0
`define TLSTW_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Descriptor and stream entry layout
// ----------------------------------------------------------------------
`define TLSTW_SPAN_MAX 5'h0B
`define TLSTW_PTR_ALIGN 5
`define TLSTW_STE_SHIFT 6
`define TLSTW_L1D_SHIFT 3
`define TLSTW_STE_VALID 0
`define TLSTW_STE_CTX_LSB 8
`define TLSTW_CACHE_IDX 4
`define TLSTW_CACHE_DEPTH 16

`endif

/* File: core/tlstw_pkg.sv */
package tlstw_pkg;

  // Walk states, one-hot.
  typedef enum logic [5:0] {
    tlstw_idle_st = 6'h01,
    tlstw_look_st = 6'h02,
    tlstw_l1_wait_st = 6'h04,
    tlstw_check_st = 6'h08,
    tlstw_ste_wait_st = 6'h10,
    tlstw_done_st = 6'h20
  } tlstw_state_type;

  // Kind of misconfiguration reported with an error event.
  typedef enum logic [1:0] {
    tlstw_ev_none = 2'h0,
    tlstw_ev_bad_stream_id = 2'h1,
    tlstw_ev_bad_ste = 2'h2
  } tlstw_event_type;

endpackage

/* File: core/tlstw_desc_mem.sv */
`timescale 1ns/1ps
`include "tlstw_defs.svh"

// Cache storage for first-level descriptors with a registered read port.
module tlstw_desc_mem (
  // Clock.
  input wire logic mclk,
  // Write port.
  input wire logic wr_en,
  input wire logic [`TLSTW_CACHE_IDX-1:0] wr_addr,
  input wire logic [79:0] wr_data,
  // Read port.
  input wire logic [`TLSTW_CACHE_IDX-1:0] rd_addr,
  output logic [79:0] rd_data
);

  logic [79:0] mem [`TLSTW_CACHE_DEPTH];

  // Storage has no reset; validity is tracked by the walker.
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

/* File: core/tlstw_walk.sv */
`timescale 1ns/1ps
`include "tlstw_defs.svh"

// Functional notes
// - Fetched stream entries and descriptors are decoded as little-endian.
// - Non-zero undefined descriptor bits always make the descriptor invalid.
// - Every defined descriptor field is checked before use.
// - Use of an invalid structure aborts the client; a bad entry always logs a typed event, a bad descriptor only if recording enabled.
// - Descriptor and stream entry reads carry the table fetch attributes.
// - Context fetch attributes come from the selected stream entry.
// - Size field is bits [4:0]; zero makes the whole span invalid.
// - Sizes 1 to 11 give two to the power size minus one entries.
// - Sizes 12 to 31 behave exactly like zero.
// - Next-level pointer is bits [51:6], other address bits zero.
// - Pointer bits 5 plus size minus one down to zero are forced zero.
// - Pointer bits [51:48] are reserved-zero.
// - Size above split plus one is invalid.
// - Identifiers beyond the second-level range of a valid descriptor fail.
// - Failed lookups abort; bad identifier event only if recording enabled.
module tlstw_walk (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // AXI4-Lite register port.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Client lookup requests.
  input wire logic cl_req_valid,
  output logic cl_req_ready,
  input wire logic [15:0] cl_req_stream_identifier,
  // Client lookup answers.
  output logic cl_rsp_valid,
  output logic cl_rsp_abort,
  output logic [51:0] cl_rsp_stream_entry_addr,
  output logic [5:0] cl_rsp_context_fetch_attributes,
  // Table memory reads.
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [51:0] mem_req_addr,
  output logic [5:0] mem_req_attr,
  input wire logic mem_rsp_valid,
  input wire logic [63:0] mem_rsp_data,
  // Error events.
  output logic ev_valid,
  output logic [1:0] ev_type,
  output logic [15:0] ev_stream_identifier
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [51:0] base;
    logic [3:0] split;
    logic [`TLSTW_CACHE_DEPTH-1:0] cvalid;
    logic inv_hit;
    tlstw_pkg::tlstw_state_type st;
    logic [15:0] sid;
    logic [15:0] l1idx;
    logic [15:0] l2idx;
    logic [63:0] desc;
    logic req_ready;
    logic rsp_valid;
    logic rsp_abort;
    logic [51:0] ste_addr;
    logic [5:0] ctx_attr;
    logic mreq_valid;
    logic [51:0] mreq_addr;
    logic [5:0] mreq_attr;
    logic ev_valid;
    tlstw_pkg::tlstw_event_type ev_type;
    logic [15:0] ev_sid;
    logic [15:0] ev_count;
  } tlstw_state_struct_type;

  tlstw_state_struct_type s_q;
  tlstw_state_struct_type s_d;

  // Cache port signals.
  logic cache_wr;
  logic [`TLSTW_CACHE_IDX-1:0] cache_rd_addr;
  logic [79:0] cache_rd;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Byte-lane merge for register writes.
  function automatic logic [31:0] tlstw_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Address decode shared by the read and write paths.
  function automatic logic tlstw_mapped(input logic [7:0] a);
    return (a == `TLSTW_OFS_CTRL) || (a == `TLSTW_OFS_BASE_LO) ||
           (a == `TLSTW_OFS_BASE_HI) || (a == `TLSTW_OFS_SPLIT) ||
           (a == `TLSTW_OFS_INVAL) || (a == `TLSTW_OFS_STATUS) ||
           (a == `TLSTW_OFS_EVENT);
  endfunction

  // Checks a first-level descriptor for the given split and index.
  function automatic logic tlstw_desc_bad(input logic [63:0] d,
                                          input logic [3:0] split,
                                          input logic [15:0] l2idx);
    logic [4:0] span;
    logic bad;
    span = d[4:0];
    bad = (span == 5'h00);
    bad = bad || (span > `TLSTW_SPAN_MAX);
    bad = bad || ({1'b0, span} > ({2'h0, split} + 6'h01));
    bad = bad || d[5] || (d[63:52] != 12'h000);
    bad = bad || (d[51:48] != 4'h0);
    if (!bad) begin
      bad = (l2idx >> (span - 5'h01)) != 16'h0000;
    end
    return bad;
  endfunction

  // --------------------------------------------------------------------
  // Descriptor cache
  // --------------------------------------------------------------------
  tlstw_desc_mem u_mem (
    .mclk(mclk),
    .wr_en(cache_wr),
    .wr_addr(s_q.l1idx[`TLSTW_CACHE_IDX-1:0]),
    .wr_data({s_q.l1idx, mem_rsp_data}),
    .rd_addr(cache_rd_addr),
    .rd_data(cache_rd)
  );

  // The lookup index is formed from the request itself so that the
  // registered cache read lands in the cycle after acceptance.
  assign cache_rd_addr = 4'(cl_req_stream_identifier >> s_q.split);

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  // Register port, invalidations and the table walk share one process so
  // that an invalidation and a cache fill in the same cycle resolve here.
  always_comb begin
    logic [51:0] ptr;
    logic [51:0] amask;
    logic [31:0] wr_val;
    logic ste_ok;
    s_d = s_q;
    ptr = 52'h0_0000_0000_0000;
    amask = 52'h0_0000_0000_0000;
    wr_val = 32'h0000_0000;
    ste_ok = 1'b0;
    cache_wr = 1'b0;
    s_d.rsp_valid = 1'b0;
    s_d.ev_valid = 1'b0;

    // Write address and data are taken in either order.
    if (s_q.awready && s_axi_awvalid) begin
      s_d.awaddr = s_axi_awaddr;
      s_d.aw_held = 1'b1;
      s_d.awready = 1'b0;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.w_held = 1'b1;
      s_d.wready = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = tlstw_mapped(s_q.awaddr) ? `TLSTW_RESP_OKAY :
                  `TLSTW_RESP_SLVERR;
      case (s_q.awaddr)
        `TLSTW_OFS_CTRL: begin
          s_d.ctrl = tlstw_merge(s_q.ctrl, s_q.wdata, s_q.wstrb);
        end
        `TLSTW_OFS_BASE_LO: begin
          s_d.base[31:0] = tlstw_merge(s_q.base[31:0], s_q.wdata,
                                       s_q.wstrb);
        end
        `TLSTW_OFS_BASE_HI: begin
          wr_val = tlstw_merge({12'h000, s_q.base[51:32]}, s_q.wdata,
                               s_q.wstrb);
          s_d.base[51:32] = wr_val[19:0];
        end
        `TLSTW_OFS_SPLIT: begin
          wr_val = tlstw_merge({28'h000_0000, s_q.split}, s_q.wdata,
                               s_q.wstrb);
          s_d.split = wr_val[3:0];
        end
        `TLSTW_OFS_INVAL: begin
          // Range and global forms both drop the whole cache, which is
          // never less than the span they cover.
          if (s_q.wdata[`TLSTW_INVAL_GLOBAL] ||
              s_q.wdata[`TLSTW_INVAL_RANGE]) begin
            s_d.cvalid = '0;
          end else begin
            s_d.cvalid[4'(s_q.wdata[15:0] >> s_q.split)] = 1'b0;
          end
          // A walk in flight must not refill a descriptor just dropped.
          s_d.inv_hit = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // Register reads answer one cycle after the address is taken.
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = tlstw_mapped(s_axi_araddr) ? `TLSTW_RESP_OKAY :
                  `TLSTW_RESP_SLVERR;
      case (s_axi_araddr)
        `TLSTW_OFS_CTRL: s_d.rdata = s_q.ctrl;
        `TLSTW_OFS_BASE_LO: s_d.rdata = s_q.base[31:0];
        `TLSTW_OFS_BASE_HI: s_d.rdata = {12'h000, s_q.base[51:32]};
        `TLSTW_OFS_SPLIT: s_d.rdata = {28'h000_0000, s_q.split};
        `TLSTW_OFS_STATUS: s_d.rdata = {s_q.ev_count, 13'h0000,
                                        s_q.ev_type,
                                        !s_q.st[0]};
        `TLSTW_OFS_EVENT: s_d.rdata = {16'h0000, s_q.ev_sid};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Memory request is held until the memory takes it.
    if (s_q.mreq_valid && mem_req_ready) begin
      s_d.mreq_valid = 1'b0;
    end

    // Table walk.
    case (s_q.st)
      tlstw_pkg::tlstw_idle_st: begin
        if (s_q.req_ready && cl_req_valid) begin
          s_d.req_ready = 1'b0;
          s_d.sid = cl_req_stream_identifier;
          s_d.l1idx = cl_req_stream_identifier >> s_q.split;
          s_d.l2idx = cl_req_stream_identifier &
                      ((16'h0001 << s_q.split) - 16'h0001);
          s_d.inv_hit = 1'b0;
          s_d.st = tlstw_pkg::tlstw_look_st;
        end
      end
      tlstw_pkg::tlstw_look_st: begin
        if (!s_q.ctrl[`TLSTW_CTRL_EN]) begin
          // Walks are refused while the unit is off.
          s_d.rsp_abort = 1'b1;
          s_d.st = tlstw_pkg::tlstw_done_st;
        end else if (s_q.cvalid[s_q.l1idx[`TLSTW_CACHE_IDX-1:0]] &&
                     cache_rd[79:64] == s_q.l1idx) begin
          s_d.desc = cache_rd[63:0];
          s_d.st = tlstw_pkg::tlstw_check_st;
        end else begin
          s_d.mreq_valid = 1'b1;
          s_d.mreq_addr = s_q.base +
                          {33'h0_0000_0000, s_q.l1idx, 3'h0};
          s_d.mreq_attr = s_q.ctrl[`TLSTW_CTRL_ATTR_LSB +: 6];
          s_d.st = tlstw_pkg::tlstw_l1_wait_st;
        end
      end
      tlstw_pkg::tlstw_l1_wait_st: begin
        if (mem_rsp_valid && !s_q.mreq_valid) begin
          // Byte 0 of the bus is the lowest-addressed byte.
          s_d.desc = mem_rsp_data;
          if (!s_q.inv_hit && !s_d.inv_hit) begin
            cache_wr = 1'b1;
            s_d.cvalid[s_q.l1idx[`TLSTW_CACHE_IDX-1:0]] = 1'b1;
          end
          s_d.st = tlstw_pkg::tlstw_check_st;
        end
      end
      tlstw_pkg::tlstw_check_st: begin
        if (tlstw_desc_bad(s_q.desc, s_q.split, s_q.l2idx)) begin
          s_d.rsp_abort = 1'b1;
          if (s_q.ctrl[`TLSTW_CTRL_REC]) begin
            s_d.ev_valid = 1'b1;
            s_d.ev_type = tlstw_pkg::tlstw_ev_bad_stream_id;
            s_d.ev_sid = s_q.sid;
            s_d.ev_count = s_q.ev_count + 16'h0001;
          end
          s_d.st = tlstw_pkg::tlstw_done_st;
        end else begin
          ptr = {s_q.desc[51:6], 6'h00};
          amask = ~((52'h0_0000_0000_0002 <<
                     (`TLSTW_PTR_ALIGN + s_q.desc[4:0] - 5'h01)) -
                    52'h0_0000_0000_0001);
          ptr = ptr & amask;
          s_d.ste_addr = ptr + {30'h0000_0000, s_q.l2idx, 6'h00};
          s_d.mreq_valid = 1'b1;
          s_d.mreq_addr = s_d.ste_addr;
          s_d.mreq_attr = s_q.ctrl[`TLSTW_CTRL_ATTR_LSB +: 6];
          s_d.st = tlstw_pkg::tlstw_ste_wait_st;
        end
      end
      tlstw_pkg::tlstw_ste_wait_st: begin
        if (mem_rsp_valid && !s_q.mreq_valid) begin
          ste_ok = mem_rsp_data[`TLSTW_STE_VALID];
          s_d.ctx_attr = mem_rsp_data[`TLSTW_STE_CTX_LSB +: 6];
          s_d.rsp_abort = !ste_ok;
          if (!ste_ok) begin
            // An invalid entry is always logged.
            s_d.ev_valid = 1'b1;
            s_d.ev_type = tlstw_pkg::tlstw_ev_bad_ste;
            s_d.ev_sid = s_q.sid;
            s_d.ev_count = s_q.ev_count + 16'h0001;
          end
          s_d.st = tlstw_pkg::tlstw_done_st;
        end
      end
      tlstw_pkg::tlstw_done_st: begin
        s_d.rsp_valid = 1'b1;
        s_d.req_ready = 1'b1;
        s_d.st = tlstw_pkg::tlstw_idle_st;
      end
      default: begin
        s_d.st = tlstw_pkg::tlstw_idle_st;
        s_d.req_ready = 1'b1;
      end
    endcase
    if (s_q.st == tlstw_pkg::tlstw_idle_st && s_d.st !=
        tlstw_pkg::tlstw_idle_st) begin
      s_d.rsp_abort = 1'b0;
      s_d.ctx_attr = 6'h00;
      s_d.ste_addr = 52'h0_0000_0000_0000;
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // Reset loads constants only; the cache contents need no reset since
  // every line starts invalid.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.ctrl <= `TLSTW_CTRL_RST;
      s_q.split <= `TLSTW_SPLIT_RST;
      s_q.st <= tlstw_pkg::tlstw_idle_st;
      s_q.req_ready <= 1'b1;
      s_q.ev_type <= tlstw_pkg::tlstw_ev_none;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Every output is a field of the state register.
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign cl_req_ready = s_q.req_ready;
  assign cl_rsp_valid = s_q.rsp_valid;
  assign cl_rsp_abort = s_q.rsp_abort;
  assign cl_rsp_stream_entry_addr = s_q.ste_addr;
  assign cl_rsp_context_fetch_attributes = s_q.ctx_attr;
  assign mem_req_valid = s_q.mreq_valid;
  assign mem_req_addr = s_q.mreq_addr;
  assign mem_req_attr = s_q.mreq_attr;
  assign ev_valid = s_q.ev_valid;
  assign ev_type = s_q.ev_type;
  assign ev_stream_identifier = s_q.ev_sid;

endmodule

/* File: tb/tlstw_walk_monitor.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Walk, fetch and event checks at the block's ports
// ---------------------------------------------------------------------
module tlstw_walk_monitor (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Client side.
  input wire logic cl_req_valid,
  input wire logic cl_req_ready,
  input wire logic cl_rsp_valid,
  input wire logic cl_rsp_abort,
  input wire logic [51:0] cl_rsp_stream_entry_addr,
  // Table memory side.
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire logic [51:0] mem_req_addr,
  input wire logic [5:0] mem_req_attr,
  input wire logic mem_rsp_valid,
  // Error events.
  input wire logic ev_valid,
  input wire logic [1:0] ev_type
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // A taken request closes the port for at least two cycles.
  sequence s_take;
    cl_req_valid && cl_req_ready;
  endsequence
  sequence s_walking;
    (!cl_req_ready && !cl_rsp_valid) [*2];
  endsequence

  AST_WALK_CLOSED: assert property (s_take |=> s_walking)
    else $error("request port open during a walk");
  AST_ANSWER_BOUND: assert property (s_take |-> ##[3:100] cl_rsp_valid)
    else $error("lookup got no answer in time");
  AST_ANSWER_PULSE: assert property (cl_rsp_valid |=> !cl_rsp_valid)
    else $error("answer longer than one cycle");
  AST_FETCH_HOLD: assert property (mem_req_valid && !mem_req_ready |=>
    mem_req_valid && $stable(mem_req_addr) && $stable(mem_req_attr))
    else $error("table fetch changed before it was taken");
  AST_ENTRY_ALIGN: assert property (
    cl_rsp_valid && !cl_rsp_abort |->
    cl_rsp_stream_entry_addr[5:0] == 6'h00 &&
    cl_rsp_stream_entry_addr[51:48] == 4'h0)
    else $error("stream entry address badly formed");
  AST_NO_EVENT_ON_HIT: assert property (
    cl_rsp_valid && !cl_rsp_abort |-> !ev_valid && !$past(ev_valid))
    else $error("event raised for a good lookup");
  AST_EVENT_TYPED: assert property (ev_valid |->
    ev_type == tlstw_pkg::tlstw_ev_bad_stream_id ||
    ev_type == tlstw_pkg::tlstw_ev_bad_ste)
    else $error("event without a known kind");
  AST_FETCH_FOLLOWUP: assert property (mem_rsp_valid |->
    ##[1:3] (mem_req_valid || cl_rsp_valid))
    else $error("fetched data not acted on in time");
endmodule

bind tlstw_walk tlstw_walk_monitor tlstw_walk_monitor_inst (.*);

/* File: tb/tlstw_mem_model.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Table memory seen by the walker
// ---------------------------------------------------------------------
module tlstw_mem_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Read requests.
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic [51:0] mem_req_addr,
  // Read answers.
  output logic mem_rsp_valid,
  output logic [63:0] mem_rsp_data,
  // Extra cycles before a request is accepted.
  input wire logic [3:0] wait_cycles
);
  logic [63:0] mem [logic [51:0]];
  logic [51:0] addr_q;
  logic [3:0] cnt_q;
  logic pend_q;

  // Accept after the stall, answer a cycle later. Between answers the
  // data bus flips every cycle, so a late sample cannot look right.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mem_req_ready <= 1'b0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= 64'h0000_0000_0000_0000;
      addr_q <= 52'h0_0000_0000_0000;
      cnt_q <= 4'h0;
      pend_q <= 1'b0;
    end else begin
      mem_req_ready <= 1'b0;
      mem_rsp_valid <= pend_q;
      mem_rsp_data <= ~mem_rsp_data;
      pend_q <= 1'b0;
      if (pend_q) begin
        mem_rsp_data <= mem.exists(addr_q) ? mem[addr_q] : 64'h0;
      end else if (mem_req_valid && mem_req_ready) begin
        addr_q <= mem_req_addr;
        pend_q <= 1'b1;
        cnt_q <= 4'h0;
      end else if (mem_req_valid) begin
        if (cnt_q == wait_cycles) mem_req_ready <= 1'b1;
        else cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

/* File: tb/test_tlstw_walk.sv */
`timescale 1ns/1ps
`include "tlstw_defs.svh"

// ---------------------------------------------------------------------
// Bench for the stream table walk
// ---------------------------------------------------------------------
module test_tlstw_walk;
  logic mclk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, ev_valid, ev_seen;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, wait_cycles;
  logic [1:0] s_axi_bresp, s_axi_rresp, ev_type, ev_got, rsp;
  logic cl_req_valid, cl_req_ready, cl_rsp_valid, cl_rsp_abort;
  logic [15:0] cl_req_stream_identifier, ev_stream_identifier;
  logic [51:0] cl_rsp_stream_entry_addr, mem_req_addr;
  logic [5:0] cl_rsp_context_fetch_attributes, mem_req_attr, last_attr;
  logic mem_req_valid, mem_req_ready, mem_rsp_valid;
  logic [63:0] mem_rsp_data;
  int n_fail = 0;
  int comparisons = 0;

  tlstw_walk tlstw_walk_inst (.*);
  tlstw_mem_model tlstw_mem_model_inst (.*);

  // Clock of 50 ns.
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // Latch events since the last taken lookup, and each fetch's attributes.
  always @(posedge mclk) begin
    if (cl_req_valid === 1'b1 && cl_req_ready === 1'b1) ev_seen <= 1'b0;
    if (ev_valid === 1'b1) begin
      ev_seen <= 1'b1;
      ev_got <= ev_type;
    end
    if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1) begin
      last_attr <= mem_req_attr;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Bus cycles; address and data go out together, each dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic put(input logic [51:0] a, input logic [63:0] d);
    tlstw_mem_model_inst.mem[a] = d;
  endtask

  // One lookup; waits past the answer so a late event is still caught.
  task automatic lookup(input logic [15:0] sid);
    cl_req_valid <= 1'b1;
    cl_req_stream_identifier <= sid;
    do @(posedge mclk); while (cl_req_ready !== 1'b1);
    cl_req_valid <= 1'b0;
    do @(posedge mclk); while (cl_rsp_valid !== 1'b1);
    repeat (3) @(posedge mclk);
  endtask

  task automatic setup(input logic [31:0] ctrl);
    axi_wr(`TLSTW_OFS_BASE_LO, 32'h0000_1000, rsp);
    axi_wr(`TLSTW_OFS_BASE_HI, 32'h0000_0000, rsp);
    axi_wr(`TLSTW_OFS_SPLIT, 32'h0000_0004, rsp);
    axi_wr(`TLSTW_OFS_CTRL, ctrl, rsp);
    axi_rd(`TLSTW_OFS_CTRL, rd, rsp);
    check(rd, ctrl);
  endtask

  // Reset values and an unmapped place, read and written.
  task automatic test_regs();
    axi_rd(`TLSTW_OFS_CTRL, rd, rsp);
    check({rsp, rd}, {`TLSTW_RESP_OKAY, `TLSTW_CTRL_RST});
    axi_rd(`TLSTW_OFS_SPLIT, rd, rsp);
    check(rd[3:0], `TLSTW_SPLIT_RST);
    axi_rd(8'h1C, rd, rsp);
    check({rsp, rd}, {`TLSTW_RESP_SLVERR, 32'h0000_0000});
    axi_wr(8'h1C, 32'hFFFF_FFFF, rsp);
    check(rsp, `TLSTW_RESP_SLVERR);
  endtask

  // Descriptor k at base plus 8k; the split of 4 makes sid {k, idx}.
  task automatic row(input logic [3:0] k, input logic [63:0] desc,
    input logic [3:0] idx, input logic [63:0] stream_entry, input logic [2:0] exp);
    logic [51:0] ad;
    ad = {desc[51:6], 6'h00} & ~((52'h1 << (5 + desc[4:0])) - 52'h1);
    ad = ad + {idx, 6'h00};
    put(52'h1000 + k * 8, desc);
    put(ad, stream_entry);
    lookup({8'h00, k, idx});
    check({cl_rsp_abort, ev_seen, ev_seen ? ev_got : 2'h0},
          {exp[2], exp});
    check(last_attr, 6'h15);
    if (exp[2]) check(ev_stream_identifier, {8'h00, k, idx});
    if (!exp[2]) check(cl_rsp_stream_entry_addr, ad);
    if (!exp[2]) check(cl_rsp_context_fetch_attributes, stream_entry[13:8]);
  endtask

  // Every span class, reserved bits, range ends and a bad entry.
  task automatic test_spans();
    wait_cycles <= 4'h2;
    row(4'h1, 64'h0000_0000_0001_0000, 4'h0, 64'h2A01, 3'b101);
    row(4'h2, 64'h0000_0000_0002_000C, 4'h0, 64'h2A01, 3'b101);
    row(4'h3, 64'h0000_0000_0003_001F, 4'h0, 64'h2A01, 3'b101);
    row(4'h4, 64'h0000_0000_0004_0006, 4'h0, 64'h2A01, 3'b101);
    row(4'h5, 64'h0000_0000_0005_0005, 4'hF, 64'h2A01, 3'b000);
    row(4'h6, 64'h0000_0000_0006_0001, 4'h1, 64'h2A01, 3'b101);
    row(4'h7, 64'h0000_0000_0007_0001, 4'h0, 64'h1501, 3'b000);
    row(4'h8, 64'h0004_0000_0008_0003, 4'h0, 64'h2A01, 3'b101);
    row(4'h9, 64'h0000_0000_0009_0023, 4'h0, 64'h2A01, 3'b101);
    row(4'hA, 64'h0000_0000_000A_00C3, 4'h2, 64'h3F01, 3'b000);
    row(4'hB, 64'h0000_0000_000B_0003, 4'h3, 64'h2A00, 3'b110);
    row(4'hC, 64'h0010_0000_000C_0003, 4'h0, 64'h2A01, 3'b101);
    wait_cycles <= 4'h0;
  endtask

  // Deactivate a cached descriptor, then drop it by each invalidation.
  task automatic test_invalidate();
    logic [31:0] kind [3];
    kind = '{32'h0000_00D0, 32'h0002_0000, 32'h0001_0000};
    for (int j = 0; j < 3; j++) begin
      put(52'h1068, 64'h0000_0000_000D_0002);
      put(52'hD_0000, 64'h0000_0000_0000_2A01);
      axi_wr(`TLSTW_OFS_INVAL, 32'h0001_0000, rsp);
      lookup(16'h00D0);
      check(cl_rsp_abort, 1'b0);
      put(52'h1068, 64'h0000_0000_0000_0000);
      axi_wr(`TLSTW_OFS_INVAL, kind[j], rsp);
      lookup(16'h00D0);
      check({cl_rsp_abort, ev_seen}, 2'b11);
    end
  endtask

  // Main sequence.
  initial begin
    reset = 1'b1;
    // Response readies stay high; the bench never stalls an answer.
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h2;
    {s_axi_rready, cl_req_valid} = 2'h2;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    cl_req_stream_identifier = 16'h0000;
    s_axi_wstrb = 4'hF;
    wait_cycles = 4'h0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    test_regs();
    lookup(16'h0010);
    check({cl_rsp_abort, ev_seen}, 2'b10);
    setup(32'h0000_1503);
    test_spans();
    setup(32'h0000_1501);
    lookup(16'h0010);
    check({cl_rsp_abort, ev_seen}, 2'b10);
    setup(32'h0000_1503);
    test_invalidate();
    finish_test();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #2_000_000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
